/* src/baud_time_base_pkg.sv */
`default_nettype none
package baud_time_base_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_COUNT  = 8'h08;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int CTRL_W       = 5;
	localparam int STAT_SIGNAL  = 0;
	localparam int STAT_CYCLE   = 1;
	localparam int STAT_BYPASS  = 2;
	localparam int STAT_ENABLE  = 3;

	// ************************************************************
	// Settings and counts
	// ************************************************************
	localparam int           NUM_OSC      = 4;
	localparam int           DIV_STAGES   = 4;
	localparam int           COUNT_W      = 7;
	localparam logic [2:0]   RATE_150_BAUD = 3'h5;
	localparam logic [15:0]  OSC_MAP      = 16'hFA50;
	localparam logic [6:0]   COUNT_PRESET = 7'h7F;
	localparam logic [3:0]   TICK_STAGES  = 4'hF;
	localparam int           FILTER_CYCLES = 8;

	typedef struct packed {
		logic       polarity_select;
		logic       glitch_filter_enable;
		logic [2:0] rate_select;
	} ctrl_t;

	localparam ctrl_t CTRL_RESET = 5'h00;

endpackage
`default_nettype wire

/* src/time_base_divider.sv */
`timescale 1ns/10ps
`default_nettype none
module time_base_divider #(
	parameter int STAGES = baud_time_base_pkg::DIV_STAGES
) (
	input  wire logic              core_clk,
	input  wire logic              rstn,
	input  wire logic              trig,
	input  wire logic              bypass,
	output logic [STAGES-1:0]      stage_q,
	output logic                   tick
);

	// ************************************************************
	// Toggle stages
	// ************************************************************
	logic [STAGES-1:0] stage_reg;
	logic [STAGES-1:0] trig_in;
	logic [STAGES-1:0] rise;

	assign trig_in[0] = trig;

	genvar k;
	generate
		for (k = 0; k < STAGES; k++) begin : g_stage
			assign rise[k] = trig_in[k] & ~stage_reg[k];
			if (k == STAGES - 1) begin : g_last
				assign trig_in[k] = bypass ? rise[k-2] : rise[k-1];
			end else if (k > 0) begin : g_mid
				assign trig_in[k] = rise[k-1];
			end
			always_ff @(posedge core_clk or negedge rstn) begin
				if (!rstn)
					stage_reg[k] <= 1'b0;
				else if (k == STAGES - 2 && bypass)
					stage_reg[k] <= 1'b0;
				else if (trig_in[k])
					stage_reg[k] <= ~stage_reg[k];
			end
		end
	endgenerate

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			tick <= 1'b0;
		else
			tick <= rise[STAGES-1];
	end

	assign stage_q = stage_reg;

endmodule // time_base_divider
`default_nettype wire

/* src/line_input_shaper.sv */
`timescale 1ns/10ps
`default_nettype none
module line_input_shaper #(
	parameter int FILTER_CYCLES = baud_time_base_pkg::FILTER_CYCLES
) (
	input  wire logic core_clk,
	input  wire logic rstn,
	input  wire logic line_mark_in,
	input  wire logic line_space_in,
	input  wire logic polarity_select,
	input  wire logic glitch_filter_enable,
	output logic      shaped_mark,
	output logic      start_edge
);

	// ************************************************************
	// Synchroniser and keyers
	// ************************************************************
	logic [1:0] meta_reg;
	logic [1:0] sync_reg;
	logic       keyer_mark;
	logic       keyer_space;
	logic       raw_mark;
	logic [7:0] hold_reg;
	logic       shaped_reg;
	logic       shaped_next;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= 2'h1;
			sync_reg <= 2'h1;
		end else begin
			meta_reg <= {line_space_in, line_mark_in};
			sync_reg <= meta_reg;
		end
	end

	assign keyer_mark  = polarity_select ? sync_reg[1] : sync_reg[0];
	assign keyer_space = polarity_select ? sync_reg[0] : sync_reg[1];
	assign raw_mark    = keyer_mark & ~keyer_space;

	// ************************************************************
	// Spike and hole filter
	// ************************************************************
	assign shaped_next = (raw_mark == shaped_reg) ? shaped_reg :
		(!glitch_filter_enable ||
		 hold_reg == 8'(FILTER_CYCLES - 1)) ? raw_mark : shaped_reg;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			hold_reg   <= 8'h00;
			shaped_reg <= 1'b1;
			start_edge <= 1'b0;
		end else begin
			hold_reg   <= (raw_mark == shaped_reg ||
				shaped_next != shaped_reg) ? 8'h00 : hold_reg + 8'h01;
			shaped_reg <= shaped_next;
			start_edge <= shaped_reg & ~shaped_next;
		end
	end

	assign shaped_mark = shaped_reg;

endmodule // line_input_shaper
`default_nettype wire

/* src/baud_time_base_generator.sv */
// Our own choices: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module baud_time_base_generator #(
	parameter int NUM_OSC       = baud_time_base_pkg::NUM_OSC,
	parameter int FILTER_CYCLES = baud_time_base_pkg::FILTER_CYCLES
) (
	input  wire logic               core_clk,
	input  wire logic               rstn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic [NUM_OSC-1:0] osc_in,
	input  wire logic               line_mark_in,
	input  wire logic               line_space_in,
	input  wire logic               char_enable_in,
	output logic                    signal_indicator,
	output logic                    first_sampler_level,
	output logic                    sampler_clock,
	output logic                    counter_preset,
	output logic [6:0]              bit_count,
	output logic                    char_restart,
	output logic                    char_cycle
);

	// ************************************************************
	// Declarations
	// ************************************************************
	baud_time_base_pkg::ctrl_t ctrl_reg;
	logic [31:0]               prdata_reg;
	logic                      pready_reg;
	logic                      pslverr_reg;
	logic [NUM_OSC-1:0]        osc_meta_reg;
	logic [NUM_OSC-1:0]        osc_sync_reg;
	logic                      osc_prev_reg;
	logic                      shaper_pulse_reg;
	logic [3:0]                div_stage;
	logic                      div_tick;
	logic                      shaped_mark;
	logic                      start_edge;
	logic                      en_prev_reg;
	logic                      sampler_reg;
	logic                      preset_reg;
	logic [6:0]                count_reg;
	logic [6:0]                count_next;
	logic                      cycle_reg;

	// ************************************************************
	// APB decode
	// ************************************************************
	wire        apb_access = psel & penable;
	wire        apb_first  = apb_access & ~pready_reg;
	wire        apb_done   = apb_access & pready_reg;
	wire        hit_ctrl   = paddr == baud_time_base_pkg::ADDR_CTRL;
	wire        hit_status = paddr == baud_time_base_pkg::ADDR_STATUS;
	wire        hit_count  = paddr == baud_time_base_pkg::ADDR_COUNT;
	wire        addr_ok    = hit_ctrl | hit_status | hit_count;
	wire        ctrl_write = apb_done & pwrite & hit_ctrl & ~pslverr_reg;
	wire [31:0] rd_ctrl    = {27'h0, ctrl_reg};
	wire [31:0] rd_count   = {25'h0, count_reg};
	wire        bypass;
	wire [31:0] rd_status;
	wire [31:0] rd_data;

	assign rd_status = {28'h0000000, char_enable_in, bypass,
		cycle_reg, shaped_mark};
	assign rd_data = hit_ctrl   ? rd_ctrl   :
	                 hit_status ? rd_status :
	                 hit_count  ? rd_count  : 32'h00000000;

	// ************************************************************
	// APB slave registers
	// ************************************************************
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h00000000;
		end else begin
			pready_reg  <= apb_first;
			pslverr_reg <= apb_first & ~addr_ok;
			if (apb_first && !pwrite)
				prdata_reg <= rd_data;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			ctrl_reg <= baud_time_base_pkg::CTRL_RESET;
		else if (ctrl_write)
			ctrl_reg <= pwdata[4:0];
	end

	assign prdata  = prdata_reg;
	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;

	// ************************************************************
	// Oscillator selection and shaping
	// ************************************************************
	wire [3:0] map_pos  = {ctrl_reg.rate_select, 1'b0};
	wire [1:0] osc_idx  = baud_time_base_pkg::OSC_MAP[map_pos +: 2];
	wire       osc_level = osc_sync_reg[osc_idx];

	assign bypass = ctrl_reg.rate_select ==
		baud_time_base_pkg::RATE_150_BAUD;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			osc_meta_reg <= '0;
			osc_sync_reg <= '0;
		end else begin
			osc_meta_reg <= osc_in;
			osc_sync_reg <= osc_meta_reg;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			osc_prev_reg     <= 1'b0;
			shaper_pulse_reg <= 1'b0;
		end else begin
			osc_prev_reg     <= osc_level;
			shaper_pulse_reg <= osc_level & ~osc_prev_reg;
		end
	end

	// ************************************************************
	// Divider chain
	// ************************************************************
	time_base_divider #(
		.STAGES (baud_time_base_pkg::DIV_STAGES)
	) u_divider (
		.core_clk (core_clk),
		.rstn     (rstn),
		.trig     (shaper_pulse_reg),
		.bypass   (bypass),
		.stage_q  (div_stage),
		.tick     (div_tick)
	);

	// ************************************************************
	// Line input
	// ************************************************************
	line_input_shaper #(
		.FILTER_CYCLES (FILTER_CYCLES)
	) u_input (
		.core_clk             (core_clk),
		.rstn                 (rstn),
		.line_mark_in         (line_mark_in),
		.line_space_in        (line_space_in),
		.polarity_select      (ctrl_reg.polarity_select),
		.glitch_filter_enable (ctrl_reg.glitch_filter_enable),
		.shaped_mark          (shaped_mark),
		.start_edge           (start_edge)
	);

	assign signal_indicator    = shaped_mark;
	assign first_sampler_level = shaped_mark;
	assign char_restart        = start_edge;

	// ************************************************************
	// Clock gate, preset and bit counter
	// ************************************************************
	wire gated_tick = div_tick & char_enable_in;
	wire enable_fall = en_prev_reg & ~char_enable_in;

	assign count_next = enable_fall ? baud_time_base_pkg::COUNT_PRESET :
		gated_tick ? count_reg + 7'h01 : count_reg;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			en_prev_reg <= 1'b0;
			sampler_reg <= 1'b0;
			preset_reg  <= 1'b0;
			count_reg   <= baud_time_base_pkg::COUNT_PRESET;
		end else begin
			en_prev_reg <= char_enable_in;
			sampler_reg <= gated_tick;
			preset_reg  <= enable_fall;
			count_reg   <= count_next;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			cycle_reg <= 1'b0;
		else if (start_edge)
			cycle_reg <= 1'b0;
		else if (enable_fall)
			cycle_reg <= 1'b1;
	end

	assign sampler_clock  = sampler_reg;
	assign counter_preset = preset_reg;
	assign bit_count      = count_reg;
	assign char_cycle     = cycle_reg;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	a_osc_select_source: assert property (
		shaper_pulse_reg |-> $past(osc_sync_reg[osc_idx]) &&
			!$past(osc_prev_reg) || $past(ctrl_write))
		else $error("shaper pulse without selected oscillator edge");

	a_shaper_one_cycle: assert property (
		shaper_pulse_reg |=> !shaper_pulse_reg)
		else $error("shaper pulse longer than one cycle");

	a_divider_tick_state: assert property (
		div_tick |-> div_stage == ($past(bypass) ?
			(baud_time_base_pkg::TICK_STAGES & 4'hB) :
			baud_time_base_pkg::TICK_STAGES))
		else $error("divider tick with wrong stage state");

	a_stage_pos_edge: assert property (
		$changed(div_stage[1]) |-> $rose(div_stage[0]))
		else $error("second stage moved without rising first stage");

	a_bypass_last_clock: assert property (
		(bypass && $past(bypass) && $changed(div_stage[3]))
			|-> $rose(div_stage[1]))
		else $error("last stage not clocked by second in bypass");

	a_third_stage_clamp: assert property (
		bypass [*2] |-> !div_stage[2])
		else $error("third stage not held low in bypass");

	a_full_chain_clock: assert property (
		(!bypass && !$past(bypass) && $changed(div_stage[3]))
			|-> $rose(div_stage[2]))
		else $error("last stage not clocked by third");

	a_gate_passes_tick: assert property (
		(div_tick && char_enable_in) |=> sampler_clock)
		else $error("tick lost while character enabled");

	a_gate_blocks_tick: assert property (
		!$past(char_enable_in) |-> !sampler_clock)
		else $error("tick passed while character disabled");

	a_preset_single: assert property (
		$fell(char_enable_in) |=> counter_preset ##1 !counter_preset)
		else $error("preset pulse missing or too long");

	a_counter_advance: assert property (
		(sampler_clock && !counter_preset)
			|-> bit_count == 7'($past(bit_count) + 7'h01))
		else $error("bit counter did not advance on gated tick");

	a_preset_value: assert property (
		counter_preset |-> bit_count == baud_time_base_pkg::COUNT_PRESET)
		else $error("preset did not load 127");

	a_restart_clears: assert property (
		char_restart |=> !char_cycle)
		else $error("character cycle not restarted");

	// ************************************************************
	// Gate, counter, line and bus checks
	// ************************************************************
	a_sampler_from_tick: assert property (
		sampler_clock
			|-> $past(div_tick) && $past(char_enable_in))
		else $error("sampler clock without gated tick");

	a_restart_on_fall: assert property (
		char_restart == $fell(signal_indicator))
		else $error("restart does not match shaped mark fall");

	a_count_hold: assert property (
		(!sampler_clock && !counter_preset)
			|-> $stable(bit_count))
		else $error("bit counter moved without tick or preset");

	a_preset_after_fall: assert property (
		counter_preset
			|-> !$past(char_enable_in) && $past(char_enable_in, 2))
		else $error("preset without enable fall");

	a_cycle_set_fall: assert property (
		(counter_preset && !$past(char_restart))
			|-> char_cycle)
		else $error("character cycle not set by enable fall");

	a_pready_single: assert property (
		pready |=> !pready)
		else $error("ready held longer than one cycle");

	a_ready_after_access: assert property (
		(psel && penable && !pready)
			|=> pready)
		else $error("ready missing after access cycle");

	a_error_with_ready: assert property (
		pslverr |-> pready)
		else $error("error flag without ready");

	a_unmapped_read_zero: assert property (
		(pready && pslverr && !pwrite)
			|-> prdata == 32'h00000000)
		else $error("unmapped read returned data");

	a_ctrl_write_only: assert property (
		!$past(ctrl_write) |-> $stable(ctrl_reg))
		else $error("control changed without a write");

	c_bypass_tick: cover property (bypass && div_tick);
	c_filter_restart: cover property (
		ctrl_reg.glitch_filter_enable && char_restart);
	c_preset_then_wrap: cover property (
		counter_preset ##[1:300] (sampler_clock && bit_count == 7'h00));
	c_restart: cover property (char_restart);
	c_apb_error: cover property (pready && pslverr);

endmodule // baud_time_base_generator
`default_nettype wire

/* sim/telegraph_line_model.sv */
`timescale 1ns/10ps
`default_nettype none
module telegraph_line_model (
	input  wire logic core_clk,
	output logic      line_mark_in,
	output logic      line_space_in
);
	// ************************************************************
	// Line keying
	// ************************************************************
	logic reversed;

	initial begin
		reversed      = 1'b0;
		line_mark_in  = 1'b1;
		line_space_in = 1'b0;
	end

	// Mark keys mark leg; polar space keys space leg; reversed swaps legs
	task automatic send(input logic mark, input logic polar);
		logic m;
		logic s;
		m = mark;
		s = !mark && polar;
		line_mark_in  <= reversed ? s : m;
		line_space_in <= reversed ? m : s;
	endtask
endmodule // telegraph_line_model
`default_nettype wire

/* sim/baud_time_base_generator_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module baud_time_base_generator_bench;
	// ************************************************************
	// Signals
	// ************************************************************
	logic        core_clk, rstn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, d;
	logic        char_enable_in, signal_indicator, first_sampler_level;
	logic        sampler_clock, counter_preset, char_restart, char_cycle;
	logic        line_mark_in, line_space_in;
	logic [6:0]  bit_count;
	logic [3:0]  osc_in;
	int          errors, total_checks, seed, ticks, restarts, n, t0;
	int          per [4] = '{6, 8, 10, 12};
	int          osc_cnt [4];
	longint      ts;
	typedef struct packed {
		logic        rd;
		logic [31:0] data;
		logic        err;
	} note_t;
	note_t       note_q [$];

	baud_time_base_generator #(.FILTER_CYCLES(2)) baud_time_base_generator_inst (
		.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .osc_in(osc_in),
		.line_mark_in(line_mark_in), .line_space_in(line_space_in),
		.char_enable_in(char_enable_in), .signal_indicator(signal_indicator),
		.first_sampler_level(first_sampler_level),
		.sampler_clock(sampler_clock), .counter_preset(counter_preset),
		.bit_count(bit_count), .char_restart(char_restart),
		.char_cycle(char_cycle));

	telegraph_line_model telegraph_line_model_inst (.core_clk(core_clk),
		.line_mark_in(line_mark_in), .line_space_in(line_space_in));

	// ************************************************************
	// Clock, oscillators, pulse counters
	// ************************************************************
	initial core_clk = 1'b0;
	always #2 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		for (int k = 0; k < 4; k++) begin
			osc_cnt[k] <= (osc_cnt[k] + 1) % per[k];
			osc_in[k]  <= (osc_cnt[k] < per[k] / 2);
		end
		if (sampler_clock === 1'b1) ticks <= ticks + 1;
		if (char_restart === 1'b1) restarts <= restarts + 1;
	end

	// ************************************************************
	// Checking
	// ************************************************************
	task automatic chk(input string nm, input logic [31:0] ex,
		input logic [31:0] got);
		total_checks++;
		if (got !== ex) begin
			errors++;
			$display("ERROR %s expected %0h seen %0h", nm, ex, got);
		end
	endtask

	always @(posedge core_clk) begin
		note_t e;
		if (psel && penable && pready === 1'b1) begin
			e = note_q.pop_front();
			if (e.rd) chk("prdata", e.data, prdata);
			chk("pslverr", 32'(e.err), 32'(pslverr));
		end
	end

	task automatic end_sim;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge core_clk);
		errors++;
		end_sim;
	end

	// ************************************************************
	// Drivers
	// ************************************************************
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] dw, input logic [31:0] ex, input logic er);
		note_q.push_back('{!wr, ex, er});
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= dw;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1)
			@(posedge core_clk);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic wait_ticks(input int goal);
		n = 0;
		while (ticks < goal && n < 20000) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 20000) chk("tick wait", 0, 1);
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		for (int k = 0; k < 4; k++) osc_cnt[k] = 0;
		{errors, total_checks, ticks, restarts} = '0;
		seed = 84;
		{rstn, psel, penable, pwrite, char_enable_in} = '0;
		{paddr, pwdata} = '0;
		repeat (5) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		apb(0, 8'h00, 0, 32'h00, 0);
		apb(0, 8'h04, 0, 32'h01, 0);
		apb(0, 8'h08, 0, 32'h7F, 0);
		apb(1, 8'h04, 32'hFFFFFFFF, 0, 0);
		apb(0, 8'h04, 0, 32'h01, 0);
		apb(0, 8'h0C, 0, 32'h00, 1);
		apb(1, 8'h0C, 32'h1F, 0, 1);
		apb(0, 8'h00, 0, 32'h00, 0);
		apb(1, 8'h00, 32'h05, 0, 0);
		apb(0, 8'h04, 0, 32'h05, 0);
		d = $random(seed);
		apb(1, 8'h00, d, 0, 0);
		apb(0, 8'h00, 0, {27'h0, d[4:0]}, 0);
		$display("test registers done");
		char_enable_in <= 1'b1;
		for (int r = 0; r < 8; r++) begin
			apb(1, 8'h00, 32'(r), 0, 0);
			wait_ticks(ticks + 3);
			ts = $time;
			wait_ticks(ticks + 1);
			chk("tick period", 32'((r == 5 ? 8 : 16) * per[r / 2]), 32'(($time - ts) / 4));
		end
		$display("test rates done");
		apb(1, 8'h00, 0, 0, 0);
		wait_ticks(ticks + 2);
		char_enable_in <= 1'b0;
		@(posedge core_clk);
		#1;
		chk("preset", 1, 32'(counter_preset));
		chk("preset count", 32'h7F, 32'(bit_count));
		@(posedge core_clk);
		#1;
		chk("preset width", 0, 32'(counter_preset));
		chk("cycle set", 1, 32'(char_cycle));
		t0 = ticks;
		repeat (400) @(posedge core_clk);
		chk("blocked ticks", 32'(t0), 32'(ticks));
		chk("held count", 32'h7F, 32'(bit_count));
		char_enable_in <= 1'b1;
		t0 = ticks;
		wait_ticks(t0 + 1);
		chk("first count", 32'h00, 32'(bit_count));
		wait_ticks(t0 + 130);
		chk("count wrap", 32'h01, 32'(bit_count));
		$display("test gate and preset done");
		telegraph_line_model_inst.send(1'b0, 1'b0);
		repeat (3) @(posedge core_clk);
		#1;
		chk("restart", 1, 32'(char_restart));
		chk("indicator", 0, 32'(signal_indicator));
		chk("sampler level", 0, 32'(first_sampler_level));
		@(posedge core_clk);
		#1;
		chk("cycle clear", 0, 32'(char_cycle));
		chk("restart width", 0, 32'(char_restart));
		@(posedge core_clk);
		t0 = restarts;
		telegraph_line_model_inst.send(1'b1, 1'b0);
		repeat (8) @(posedge core_clk);
		chk("mark restarts", 32'(t0), 32'(restarts));
		chk("indicator mark", 1, 32'(signal_indicator));
		for (int p = 0; p < 2; p++) begin
			telegraph_line_model_inst.reversed = p[0];
			apb(1, 8'h00, 32'(p) << 4, 0, 0);
			for (int k = 0; k < 3; k++) begin
				telegraph_line_model_inst.send(k != 1, 1'b1);
				repeat (8) @(posedge core_clk);
				chk("polar level", 32'(k != 1), 32'(signal_indicator));
			end
		end
		telegraph_line_model_inst.reversed = 1'b0;
		telegraph_line_model_inst.send(1'b1, 1'b0);
		for (int f = 0; f < 2; f++) begin
			apb(1, 8'h00, 32'(f) << 3, 0, 0);
			repeat (8) @(posedge core_clk);
			t0 = restarts;
			telegraph_line_model_inst.send(1'b0, 1'b0);
			@(posedge core_clk);
			telegraph_line_model_inst.send(1'b1, 1'b0);
			repeat (12) @(posedge core_clk);
			telegraph_line_model_inst.send(1'b0, 1'b0);
			repeat (12) @(posedge core_clk);
			telegraph_line_model_inst.send(1'b1, 1'b0);
			@(posedge core_clk);
			telegraph_line_model_inst.send(1'b0, 1'b0);
			repeat (12) @(posedge core_clk);
			chk("filter restarts", 32'(f ? 1 : 3), 32'(restarts - t0));
			telegraph_line_model_inst.send(1'b1, 1'b0);
		end
		$display("test line input done");
		end_sim;
	end
endmodule // baud_time_base_generator_bench
`default_nettype wire
